// ---- core/port_mode_pkg.sv ----
// Constants for the per-port mode decoder and overhead integrator.
// Assumes one port per instance, all logic on the port's receive clock.
package port_mode_pkg;
   // Framing select codes
   localparam logic [2:0] FRM_DS3_CBIT = 3'h0;
   localparam logic [2:0] FRM_DS3_M13 = 3'h1;
   localparam logic [2:0] FRM_E3_G751 = 3'h2;
   localparam logic [2:0] FRM_E3_G832 = 3'h3;
   localparam logic [2:0] FRM_DS3_CLEAR = 3'h4;
   // Field positions inside the selects
   localparam int CLEAR_BIT = 2;
   localparam int E3_BIT = 1;
   localparam int UNIPOLAR_BIT = 2;
   // Line select codes
   localparam logic [2:0] LINE_ALL_OFF = 3'h0;
   localparam logic [2:0] LINE_LIU_ON = 3'h1;
   localparam logic [2:0] LINE_JITTER_TX = 3'h2;
   localparam logic [2:0] LINE_JITTER_RX = 3'h3;
   // Integrator counts
   localparam int INTEG_COUNT = 5;
   localparam int UNSTABLE_COUNT = 8;
   localparam int CNT_W = 4;
   // Framing mode decode
   typedef enum logic [5:0] {
      FMODE_DS3_CBIT = 6'h01,
      FMODE_DS3_M13 = 6'h02,
      FMODE_E3_G751 = 6'h04,
      FMODE_E3_G832 = 6'h08,
      FMODE_DS3_CLEAR = 6'h10,
      FMODE_E3_CLEAR = 6'h20
   } frame_mode_t;
endpackage

// ---- core/port_mode_decode_integrator.sv ----
// Per-port pin mux, line mode decode and overhead field integrator.
// Assumes mode inputs are quasi-static config on sys_clk_i; pins synced here.
`timescale 1ns/100ps

// What this block does
// - Shared pin: enable, frame start, or constant
// - Clock out gapped by enable when selected, framed modes only
// - Unused multiplexed inputs feed constant zero
// - Decode framing select into six modes
// - Bit error tester allowed in all modes
// - Decode line select: LINE_INTERFACE_UNIT, jitter attenuator, unipolar
// - DS3 uses B3ZS, E3 uses HDB3
// - Code bit 0 substitution, 1 plain AMI
// - Unipolar: no transform, violation counter still counts
// - Loopback in all modes, digital when LINE_INTERFACE_UNIT off
// - Framer input from LINE_INTERFACE_UNIT or external pins
// - Transmit bytes MSB first, first bit at 7
// - Receive bytes MSB first, first bit at 7
// - Store field after five equal new values
// - Unstable after eight values matching neither
// - Unstable clears after five equal values
module port_mode_decode_integrator
   import port_mode_pkg::*;
#(
   parameter int FIELD_W = 8
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Mode configuration
   input wire logic [2:0] framing_select_i,
   input wire logic [2:0] line_select_i,
   input wire logic rx_frame_start_select_i,
   input wire logic rx_clock_select_i,
   input wire logic clear_serial_mode_i,
   input wire logic tx_ami_select_i,
   input wire logic rx_ami_select_i,
   input wire logic analog_loopback_i,
   input wire logic bit_error_tester_en_i,
   // Framer-side receive events
   input wire logic rx_data_enable_i,
   input wire logic rx_frame_start_i,
   input wire logic rx_line_clock_en_i,
   // Line side pins
   input wire logic rx_line_data_i,
   input wire logic rx_positive_rail_i,
   input wire logic rx_negative_rail_i,
   input wire logic liu_rx_data_i,
   input wire logic liu_rx_neg_i,
   input wire logic tx_line_clock_i,
   input wire logic tx_positive_rail_i,
   input wire logic tx_negative_rail_i,
   // Byte serialisation
   input wire logic [7:0] tx_byte_i,
   input wire logic tx_byte_load_i,
   input wire logic rx_bit_i,
   input wire logic rx_bit_valid_i,
   // Overhead field integration
   input wire logic [FIELD_W-1:0] ovh_field_i,
   input wire logic ovh_field_valid_i,
   // Mode decode outputs
   output frame_mode_t frame_mode_o,
   output logic framed_serial_mode_o,
   output logic clear_rate_mode_o,
   output logic e3_mode_o,
   output logic line_interface_unit_en_o,
   output logic jitter_attenuator_tx_o,
   output logic jitter_attenuator_rx_o,
   output logic unipolar_mode_o,
   output logic tx_substitution_disable_o,
   output logic rx_substitution_disable_o,
   output logic b3zs_code_o,
   output logic hdb3_code_o,
   output logic line_coder_bypass_o,
   output logic bit_error_tester_allowed_o,
   output logic bipolar_violation_counter_inc_o,
   // Receive serial port pins
   output logic rx_frame_start_out_o,
   output logic rx_clock_gate_o,
   // Framer input selection
   output logic framer_rx_pos_o,
   output logic framer_rx_neg_o,
   output logic framer_rx_clock_en_o,
   // Byte serialisation
   output logic tx_serial_bit_o,
   output logic [7:0] rx_byte_o,
   output logic rx_byte_valid_o,
   // Integrated field
   output logic [FIELD_W-1:0] ovh_field_stored_o,
   output logic ovh_unstable_o
);

   // Pin synchronisers, two stages each
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end else begin
         pin_s1_q <= {rx_line_data_i, rx_positive_rail_i, rx_negative_rail_i,
                      tx_line_clock_i, tx_positive_rail_i, tx_negative_rail_i};
         pin_s2_q <= pin_s1_q;
      end
   end
   logic rdat_s, rpos_s, rneg_s, tclk_s, tx_positive_rail_s, tx_negative_rail_s;
   assign {rdat_s, rpos_s, rneg_s, tclk_s, tx_positive_rail_s, tx_negative_rail_s} = pin_s2_q;

   // Framing decode, one-hot; the default takes 101 and 11X, all three as E3 clear
   always_comb begin
      case (framing_select_i)
         FRM_DS3_CBIT: frame_mode_o = FMODE_DS3_CBIT;
         FRM_DS3_M13: frame_mode_o = FMODE_DS3_M13;
         FRM_E3_G751: frame_mode_o = FMODE_E3_G751;
         FRM_E3_G832: frame_mode_o = FMODE_E3_G832;
         FRM_DS3_CLEAR: frame_mode_o = FMODE_DS3_CLEAR;
         default: frame_mode_o = FMODE_E3_CLEAR;
      endcase
   end
   assign framed_serial_mode_o = !framing_select_i[CLEAR_BIT];
   assign clear_rate_mode_o = framing_select_i[CLEAR_BIT];
   // E3 when G.751/G.832, or any clear code above the DS3 one, as the one-hot decode
   assign e3_mode_o = framing_select_i[CLEAR_BIT] ? (framing_select_i[1:0] != 2'b00)
                                                  : framing_select_i[E3_BIT];
   // Tester never gated by framing decode
   assign bit_error_tester_allowed_o = bit_error_tester_en_i;

   // Line mode decode
   always_comb begin
      line_interface_unit_en_o = 1'b0;
      jitter_attenuator_tx_o = 1'b0;
      jitter_attenuator_rx_o = 1'b0;
      unipolar_mode_o = line_select_i[UNIPOLAR_BIT];
      // Unipolar codes keep the line unit and attenuator off
      if (!line_select_i[UNIPOLAR_BIT]) begin
         case (line_select_i)
            LINE_ALL_OFF: line_interface_unit_en_o = 1'b0;
            LINE_LIU_ON: line_interface_unit_en_o = 1'b1;
            LINE_JITTER_TX: begin
               line_interface_unit_en_o = 1'b1;
               jitter_attenuator_tx_o = 1'b1;
            end
            LINE_JITTER_RX: begin
               line_interface_unit_en_o = 1'b1;
               jitter_attenuator_rx_o = 1'b1;
            end
            default: line_interface_unit_en_o = 1'b0;
         endcase
      end
   end

   // Line code choice; unipolar bypasses the coder entirely
   assign tx_substitution_disable_o = !unipolar_mode_o && tx_ami_select_i;
   assign rx_substitution_disable_o = !unipolar_mode_o && rx_ami_select_i;
   assign b3zs_code_o = !unipolar_mode_o && !e3_mode_o;
   assign hdb3_code_o = !unipolar_mode_o && e3_mode_o;
   assign line_coder_bypass_o = unipolar_mode_o;

   // Framer input: LINE_INTERFACE_UNIT, loopback, or external pins
   always_comb begin
      if (analog_loopback_i && !line_interface_unit_en_o) begin
         framer_rx_pos_o = tx_positive_rail_s;
         framer_rx_neg_o = tx_negative_rail_s;
         framer_rx_clock_en_o = tclk_s;
      end else if (line_interface_unit_en_o) begin
         // Analog loopback happens inside the LINE_INTERFACE_UNIT, data still arrives here
         framer_rx_pos_o = liu_rx_data_i;
         framer_rx_neg_o = liu_rx_neg_i;
         framer_rx_clock_en_o = rx_line_clock_en_i;
      end else begin
         framer_rx_pos_o = unipolar_mode_o ? rdat_s : rpos_s;
         framer_rx_neg_o = rneg_s;
         framer_rx_clock_en_o = rx_line_clock_en_i;
      end
   end

   // Violation counter sees raw negative rail pulses in unipolar mode
   logic rneg_prev_q;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) rneg_prev_q <= 1'b0;
      else rneg_prev_q <= framer_rx_neg_o;
   end
   assign bipolar_violation_counter_inc_o =
      unipolar_mode_o && framer_rx_neg_o && !rneg_prev_q;

   // Frame start input is meaningless outside framed modes, so it is forced to zero
   logic fs_used;
   assign fs_used = framed_serial_mode_o & rx_frame_start_i;
   // Shared receive pin; clear modes force a level, unused inputs read zero
   always_comb begin
      if (framed_serial_mode_o)
         rx_frame_start_out_o = rx_frame_start_select_i ? fs_used
                                                        : rx_data_enable_i;
      else
         rx_frame_start_out_o = clear_serial_mode_i;
   end
   // Clock gate: 1 lets the clock through on this cycle
   assign rx_clock_gate_o = (framed_serial_mode_o && !rx_clock_select_i)
                            ? rx_data_enable_i : 1'b1;

   // Transmit byte shifter, MSB first
   logic [7:0] tx_shift_q;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) tx_shift_q <= 8'h00;
      else if (tx_byte_load_i) tx_shift_q <= tx_byte_i;
      else tx_shift_q <= {tx_shift_q[6:0], 1'b0};
   end
   assign tx_serial_bit_o = tx_shift_q[7];

   // Receive byte assembler, first bit lands in bit 7
   // Bit counter is only cleared by reset; a cut byte stays misaligned
   logic [7:0] rx_shift_q;
   logic [2:0] rx_cnt_q;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_shift_q <= 8'h00;
         rx_cnt_q <= 3'h0;
         rx_byte_o <= 8'h00;
         rx_byte_valid_o <= 1'b0;
      end else begin
         rx_byte_valid_o <= 1'b0;
         if (rx_bit_valid_i) begin
            rx_shift_q <= {rx_shift_q[6:0], rx_bit_i};
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'h7) begin
               rx_byte_o <= {rx_shift_q[6:0], rx_bit_i};
               rx_byte_valid_o <= 1'b1;
            end
         end
      end
   end

   // Integrator: run length of equal values and count of erratic values
   // A value equal to the stored one is not erratic and restarts that run
   logic [FIELD_W-1:0] prev_q;
   logic [CNT_W-1:0] same_cnt_q;
   logic [CNT_W-1:0] unst_cnt_q;
   logic same_as_prev;
   logic [CNT_W-1:0] same_next;
   assign same_as_prev = (ovh_field_i == prev_q);
   assign same_next = same_as_prev ? same_cnt_q + CNT_W'(1) : CNT_W'(1);
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= '0;
         same_cnt_q <= '0;
         unst_cnt_q <= '0;
         ovh_field_stored_o <= '0;
         ovh_unstable_o <= 1'b0;
      end else if (ovh_field_valid_i) begin
         prev_q <= ovh_field_i;
         // Saturate so a long steady run cannot wrap
         same_cnt_q <= (same_next > CNT_W'(INTEG_COUNT)) ? CNT_W'(INTEG_COUNT) : same_next;
         if (same_next >= CNT_W'(INTEG_COUNT)) begin
            ovh_field_stored_o <= ovh_field_i;
            ovh_unstable_o <= 1'b0;
         end
         if (!same_as_prev && ovh_field_i != ovh_field_stored_o) begin
            if (unst_cnt_q + CNT_W'(1) >= CNT_W'(UNSTABLE_COUNT))
               ovh_unstable_o <= 1'b1;
            else
               unst_cnt_q <= unst_cnt_q + CNT_W'(1);
         end else begin
            unst_cnt_q <= '0;
         end
      end
   end

   // Checks, grouped by concern
   // Integrator checks
   // Store and clear share one trigger, so both are checked from it
   sequence five_same_s;
      (ovh_field_valid_i && same_next >= CNT_W'(INTEG_COUNT));
   endsequence
   AST_STORE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      five_same_s |=> ovh_field_stored_o == $past(ovh_field_i))
      else $error("stored field not updated after five");
   AST_UNST_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      five_same_s |=> !ovh_unstable_o) else $error("unstable not cleared");
   AST_UNST_SET: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $rose(ovh_unstable_o) |-> $past(unst_cnt_q) == CNT_W'(UNSTABLE_COUNT - 1))
      else $error("unstable raised at wrong count");

   // Shared pin and clock checks
   // Unused frame start must never leak onto the pin in clear modes
   AST_PIN_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clear_rate_mode_o |-> rx_frame_start_out_o == clear_serial_mode_i)
      else $error("clear mode pin level wrong");
   AST_PIN_FR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      framed_serial_mode_o && !rx_frame_start_select_i |->
         rx_frame_start_out_o == rx_data_enable_i) else $error("pin not enable");
   AST_PIN_SOF: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      framed_serial_mode_o && rx_frame_start_select_i |->
         rx_frame_start_out_o == rx_frame_start_i) else $error("pin not frame start");
   AST_GAP: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !rx_clock_gate_o |-> framed_serial_mode_o && !rx_clock_select_i && !rx_data_enable_i)
      else $error("clock gapped wrongly");
   AST_FS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !framed_serial_mode_o && rx_frame_start_i |-> rx_frame_start_out_o == clear_serial_mode_i)
      else $error("unused frame start reached the pin");

   // Mode and line code checks
   // Rate taken from the one-hot decode, not from the E3 flag it guards
   AST_MODE_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clear_rate_mode_o |-> frame_mode_o inside {FMODE_DS3_CLEAR, FMODE_E3_CLEAR})
      else $error("clear select decoded as framed");
   AST_CODE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !unipolar_mode_o |->
         b3zs_code_o == (frame_mode_o inside {FMODE_DS3_CBIT, FMODE_DS3_M13, FMODE_DS3_CLEAR}))
      else $error("line code does not follow rate");
   AST_AMI: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !line_select_i[UNIPOLAR_BIT] |-> tx_substitution_disable_o == tx_ami_select_i &&
         rx_substitution_disable_o == rx_ami_select_i) else $error("code select ignored");
   AST_UNIPOLAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      unipolar_mode_o |-> !line_interface_unit_en_o && !jitter_attenuator_rx_o)
      else $error("unipolar with LINE_INTERFACE_UNIT on");
   AST_VIOL_CNT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      unipolar_mode_o && $rose(framer_rx_neg_o) |-> bipolar_violation_counter_inc_o)
      else $error("rail pulse not counted");

   // Line side source checks
   // Pins reach the framer through two sync stages, hence the depth of two
   AST_LOOP: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $past(arst_n_i, 2) && analog_loopback_i && !line_interface_unit_en_o |->
         framer_rx_pos_o == $past(tx_positive_rail_i, 2) &&
         framer_rx_neg_o == $past(tx_negative_rail_i, 2) &&
         framer_rx_clock_en_o == $past(tx_line_clock_i, 2)) else $error("loopback lost");
   AST_FROM_LINE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      line_interface_unit_en_o |-> framer_rx_pos_o == liu_rx_data_i &&
         framer_rx_neg_o == liu_rx_neg_i) else $error("framer not fed by line unit");

   // Serial order checks
   // Only the last bit is checked here; the bench checks the whole byte
   sequence byte_end_s;
      (rx_bit_valid_i && rx_cnt_q == 3'h7);
   endsequence
   AST_RXBYTE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      byte_end_s |=> rx_byte_valid_o && rx_byte_o[0] == $past(rx_bit_i))
      else $error("last received bit not at bit 0");
   AST_TXBIT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      tx_byte_load_i ##1 !tx_byte_load_i |-> tx_serial_bit_o == $past(tx_byte_i[7], 1) ##0
      1'b1) else $error("tx MSB not first");
endmodule

// ---- tb/rx_payload_sink.sv ----
// Downstream payload logic model on the receive serial port.
// Assumes the receive clock output acts as a gate on the port's own clock.
`timescale 1ns/100ps
module rx_payload_sink (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Receive serial port pins
   input wire logic gate_i,
   // Observed count
   output logic [15:0] clk_cnt_o
);
   // Count clock pulses that reach the payload logic; a gap is a lost pulse
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_cnt_o <= 16'h0;
      end else if (gate_i) begin
         clk_cnt_o <= clk_cnt_o + 16'h1;
      end
   end
endmodule

// ---- tb/test_port_mode_decode_integrator.sv ----
// Self-checking bench for the port mode decoder and field integrator.
// Assumes the design package is compiled first and the sink model exists.
`timescale 1ns/100ps
module test_port_mode_decode_integrator;
   import port_mode_pkg::*;
   logic sys_clk_i, arst_n_i, rx_frame_start_select_i, rx_clock_select_i, clear_serial_mode_i;
   logic tx_ami_select_i, rx_ami_select_i, analog_loopback_i, bit_error_tester_en_i;
   logic rx_data_enable_i, rx_frame_start_i, rx_line_clock_en_i, rx_line_data_i;
   logic rx_positive_rail_i, rx_negative_rail_i, liu_rx_data_i, liu_rx_neg_i, tx_line_clock_i;
   logic tx_positive_rail_i, tx_negative_rail_i, tx_byte_load_i, rx_bit_i, rx_bit_valid_i;
   logic ovh_field_valid_i;
   logic [2:0] framing_select_i, line_select_i;
   logic [7:0] tx_byte_i, ovh_field_i, rx_byte_o, ovh_field_stored_o;
   frame_mode_t frame_mode_o;
   logic framed_serial_mode_o, clear_rate_mode_o, e3_mode_o, line_interface_unit_en_o;
   logic jitter_attenuator_tx_o, jitter_attenuator_rx_o, unipolar_mode_o, b3zs_code_o;
   logic tx_substitution_disable_o, rx_substitution_disable_o, hdb3_code_o, line_coder_bypass_o;
   logic bit_error_tester_allowed_o, bipolar_violation_counter_inc_o, rx_frame_start_out_o;
   logic rx_clock_gate_o, framer_rx_pos_o, framer_rx_neg_o, framer_rx_clock_en_o;
   logic tx_serial_bit_o, rx_byte_valid_o, ovh_unstable_o;
   logic [15:0] clk_cnt;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;

   port_mode_decode_integrator dut (.sys_clk_i, .arst_n_i, .framing_select_i, .line_select_i,
      .rx_frame_start_select_i, .rx_clock_select_i, .clear_serial_mode_i, .tx_ami_select_i,
      .rx_ami_select_i, .analog_loopback_i, .bit_error_tester_en_i, .rx_data_enable_i,
      .rx_frame_start_i, .rx_line_clock_en_i, .rx_line_data_i, .rx_positive_rail_i,
      .rx_negative_rail_i, .liu_rx_data_i, .liu_rx_neg_i, .tx_line_clock_i, .tx_positive_rail_i,
      .tx_negative_rail_i, .tx_byte_i, .tx_byte_load_i, .rx_bit_i, .rx_bit_valid_i, .ovh_field_i,
      .ovh_field_valid_i, .frame_mode_o, .framed_serial_mode_o, .clear_rate_mode_o, .e3_mode_o,
      .line_interface_unit_en_o, .jitter_attenuator_tx_o, .jitter_attenuator_rx_o,
      .unipolar_mode_o, .tx_substitution_disable_o, .rx_substitution_disable_o, .b3zs_code_o,
      .hdb3_code_o, .line_coder_bypass_o, .bit_error_tester_allowed_o,
      .bipolar_violation_counter_inc_o, .rx_frame_start_out_o, .rx_clock_gate_o,
      .framer_rx_pos_o, .framer_rx_neg_o, .framer_rx_clock_en_o, .tx_serial_bit_o, .rx_byte_o,
      .rx_byte_valid_o, .ovh_field_stored_o, .ovh_unstable_o);

   rx_payload_sink sink (.clk_i(sys_clk_i), .rst_n_i(arst_n_i), .gate_i(rx_clock_gate_o),
      .clk_cnt_o(clk_cnt));

   // 10 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk_bit(string n, logic e, logic g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_vec(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end

   task automatic step;
      @(posedge sys_clk_i);
      #1;
   endtask

   // Every framing code but 101, which also decodes to E3 clear but would fail the f[1] expectations here
   task automatic t_frame;
      logic [5:0] m;
      for (int f = 0; f < 8; f++) begin
         if (f == 5) continue;
         @(posedge sys_clk_i);
         framing_select_i <= f[2:0];
         bit_error_tester_en_i <= 1'b1;
         #1;
         m = (f < 4) ? 6'h01 << f : (f == 4) ? 6'h10 : 6'h20;
         chk_vec("frame_mode", {10'h0, m}, {10'h0, frame_mode_o});
         chk_bit("framed", !f[2], framed_serial_mode_o);
         chk_bit("clear", f[2], clear_rate_mode_o);
         chk_bit("b3zs", !f[1], b3zs_code_o);
         chk_bit("hdb3", f[1], hdb3_code_o);
         chk_bit("e3", f[1], e3_mode_o);
         chk_bit("tester", 1'b1, bit_error_tester_allowed_o);
      end
   endtask

   // Shared pin and clock gating, gaps counted by the sink
   task automatic t_pins;
      logic [15:0] c0;
      @(posedge sys_clk_i);
      framing_select_i <= FRM_DS3_CBIT;
      rx_data_enable_i <= 1'b1;
      rx_frame_start_i <= 1'b0;
      #1;
      chk_bit("pin_den", 1'b1, rx_frame_start_out_o);
      @(posedge sys_clk_i);
      rx_frame_start_select_i <= 1'b1;
      #1;
      chk_bit("pin_sof0", 1'b0, rx_frame_start_out_o);
      @(posedge sys_clk_i);
      rx_frame_start_i <= 1'b1;
      rx_data_enable_i <= 1'b0;
      #1;
      chk_bit("pin_sof1", 1'b1, rx_frame_start_out_o);
      chk_bit("gap", 1'b0, rx_clock_gate_o);
      c0 = clk_cnt;
      @(posedge sys_clk_i);
      rx_data_enable_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rx_data_enable_i <= 1'b0;
      repeat (3) step();
      chk_vec("gapped_pulses", 16'd3, clk_cnt - c0);
      @(posedge sys_clk_i);
      rx_clock_select_i <= 1'b1;
      #1;
      chk_bit("ungapped", 1'b1, rx_clock_gate_o);
      for (int v = 0; v < 2; v++) begin
         @(posedge sys_clk_i);
         framing_select_i <= FRM_DS3_CLEAR;
         rx_clock_select_i <= 1'b0;
         clear_serial_mode_i <= v[0];
         #1;
         chk_bit("pin_clear", v[0], rx_frame_start_out_o);
         chk_bit("clk_clear", 1'b1, rx_clock_gate_o);
      end
   endtask

   // Every line code, plus pulse counting in unipolar mode
   task automatic t_line;
      logic [15:0] n;
      for (int l = 0; l < 8; l++) begin
         @(posedge sys_clk_i);
         line_select_i <= l[2:0];
         tx_ami_select_i <= 1'b1;
         rx_ami_select_i <= l[0];
         #1;
         chk_bit("liu", l > 0 && l < 4, line_interface_unit_en_o);
         chk_bit("ja_tx", l == 2, jitter_attenuator_tx_o);
         chk_bit("ja_rx", l == 3, jitter_attenuator_rx_o);
         chk_bit("unipolar", l[2], unipolar_mode_o);
         chk_bit("bypass", l[2], line_coder_bypass_o);
         if (!l[2]) begin
            chk_bit("tx_ami", 1'b1, tx_substitution_disable_o);
            chk_bit("rx_ami", l[0], rx_substitution_disable_o);
         end
      end
      n = 16'h0;
      @(posedge sys_clk_i);
      rx_negative_rail_i <= 1'b1;
      repeat (6) begin
         step();
         if (bipolar_violation_counter_inc_o === 1'b1) n++;
      end
      chk_vec("bpv_pulses", 16'd1, n);
   endtask

   // Framer source: LINE_INTERFACE_UNIT, digital loopback, external pins
   task automatic t_path;
      @(posedge sys_clk_i);
      line_select_i <= LINE_LIU_ON;
      liu_rx_data_i <= 1'b1;
      #1;
      chk_bit("from_liu", 1'b1, framer_rx_pos_o);
      chk_bit("from_liu_neg", 1'b0, framer_rx_neg_o);
      @(posedge sys_clk_i);
      line_select_i <= LINE_ALL_OFF;
      analog_loopback_i <= 1'b1;
      tx_positive_rail_i <= 1'b1;
      tx_line_clock_i <= 1'b1;
      repeat (4) step();
      chk_bit("loop", 1'b1, framer_rx_pos_o);
      chk_bit("loop_neg", 1'b0, framer_rx_neg_o);
      chk_bit("loop_clk", 1'b1, framer_rx_clock_en_o);
      @(posedge sys_clk_i);
      analog_loopback_i <= 1'b0;
      repeat (4) step();
      chk_bit("from_pin", 1'b0, framer_rx_pos_o);
      chk_bit("from_pin_neg", 1'b1, framer_rx_neg_o);
      chk_bit("from_pin_clk", 1'b0, framer_rx_clock_en_o);
   endtask

   // Serial order of bytes in both directions
   task automatic t_bytes;
      logic [7:0] r;
      r = 8'h3c;
      for (int i = 7; i >= 0; i--) begin
         @(posedge sys_clk_i);
         rx_bit_i <= r[i];
         rx_bit_valid_i <= 1'b1;
      end
      @(posedge sys_clk_i);
      rx_bit_valid_i <= 1'b0;
      #1;
      chk_vec("rx_byte", 16'h3c, {8'h0, rx_byte_o});
      chk_bit("rx_valid", 1'b1, rx_byte_valid_o);
      @(posedge sys_clk_i);
      tx_byte_i <= 8'ha5;
      tx_byte_load_i <= 1'b1;
      @(posedge sys_clk_i);
      tx_byte_load_i <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #1;
         chk_bit("tx_bit", tx_byte_i[i], tx_serial_bit_o);
         @(posedge sys_clk_i);
      end
   endtask

   task automatic fld(logic [7:0] v, int k);
      repeat (k) begin
         @(posedge sys_clk_i);
         ovh_field_i <= v;
         ovh_field_valid_i <= 1'b1;
      end
      @(posedge sys_clk_i);
      ovh_field_valid_i <= 1'b0;
      step();
   endtask

   // Integration boundaries: four then five repeats, seven then eight changes
   task automatic t_integ;
      fld(8'h11, 4);
      chk_vec("stored4", 16'h0, {8'h0, ovh_field_stored_o});
      fld(8'h11, 1);
      chk_vec("stored5", 16'h11, {8'h0, ovh_field_stored_o});
      for (int i = 0; i < 7; i++) fld(8'h20 + i[7:0], 1);
      chk_bit("unstable7", 1'b0, ovh_unstable_o);
      fld(8'h27, 1);
      chk_bit("unstable8", 1'b1, ovh_unstable_o);
      fld(8'h55, 5);
      chk_bit("unstable_clr", 1'b0, ovh_unstable_o);
      chk_vec("stored55", 16'h55, {8'h0, ovh_field_stored_o});
   endtask

   initial begin
      {framing_select_i, line_select_i, rx_frame_start_select_i, rx_clock_select_i} = '0;
      {clear_serial_mode_i, tx_ami_select_i, rx_ami_select_i, analog_loopback_i} = '0;
      {bit_error_tester_en_i, rx_data_enable_i, rx_frame_start_i, rx_line_clock_en_i} = '0;
      {rx_line_data_i, rx_positive_rail_i, rx_negative_rail_i, liu_rx_data_i} = '0;
      {liu_rx_neg_i, tx_line_clock_i, tx_positive_rail_i, tx_negative_rail_i} = '0;
      {tx_byte_i, tx_byte_load_i, rx_bit_i, rx_bit_valid_i, ovh_field_i, ovh_field_valid_i} = '0;
      arst_n_i = 1'b0;
      repeat (6) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      t_bytes();
      t_integ();
      t_frame();
      t_pins();
      t_line();
      t_path();
      summarize();
   end
endmodule
